// *** adc_front_model.sv ***
/*
 * Behavioural analog front end that feeds the conversion control block.
 * Assumes the bench sets the light level and commands short overload bursts.
 */
`timescale 1ns/1ps
`default_nettype none

module adc_front_model (
	input  wire logic        conv_active,
	input  wire logic [11:0] light_level,
	input  wire logic        burst,
	output logic      [11:0] adc_mantissa,
	output logic             adc_overload
);
	// Outside a conversion the mantissa is not held, so stale data cannot pass as a result.
	assign adc_mantissa = conv_active ? light_level : ~light_level;
	assign adc_overload = conv_active & burst;
endmodule : adc_front_model

`default_nettype wire

// *** fault_qualifier.sv ***
/*
 * Counts consecutive qualifying measurements and pulses once the selected
 * count of one, two, four or eight is reached.
 * Assumes step is a one-cycle pulse per finished measurement.
 */
`timescale 1ns/1ps
`default_nettype none

module fault_qualifier
	import light_sensor_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	input  wire logic       step,
	input  wire logic       hit,
	input  wire logic [1:0] count_sel,
	output logic            fire
);

	logic [3:0] run_ff;
	logic [3:0] need;
	logic [3:0] run_inc;
	logic [3:0] nxt_run;

	assign need    = 4'(4'h1 << count_sel);
	assign run_inc = (run_ff >= need) ? need : 4'(run_ff + 4'h1);
	assign nxt_run = step ? (hit ? run_inc : 4'h0) : run_ff;
	assign fire    = step && hit && (run_inc >= need);

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			run_ff <= 4'h0;
		end else begin
			run_ff <= nxt_run;
		end
	end

	AST_FIRE_NEEDS_RUN: assert property (@(posedge sys_clk) disable iff (!rst_n)
		fire |-> (4'(run_ff + 4'h1) >= need))
		else $error("fault pulse before enough consecutive hits");

endmodule : fault_qualifier

`default_nettype wire

// *** light_sensor_conversion_control_tb.sv ***
/*
 * Self-checking bench of the conversion control and status register.
 * Assumes the package, the design modules and the front-end model compile first.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin fail_count++; \
	$display("[ERR] %s exp %h got %h", nm, e, g); end end

module light_sensor_conversion_control_tb;
	localparam int SHORT = 10;
	localparam int LONG  = 80;
	logic        sys_clk     = 1'b0;
	logic        rst_n       = 1'b0;
	logic        reg_wr      = 1'b0;
	logic        reg_rd      = 1'b0;
	logic [15:0] reg_wdata   = 16'h0000;
	logic [15:0] high_limit  = 16'hBFFF;
	logic [15:0] low_limit   = 16'h0000;
	logic [11:0] light_level = 12'h000;
	logic        burst       = 1'b0;
	logic [15:0] rnd         = 16'h0013;
	logic [15:0] reg_rdata;
	logic [15:0] result_data;
	logic [11:0] adc_mantissa;
	logic        adc_overload;
	logic        conv_active;
	logic [1:0]  res_drop_bits;
	logic        limit_alert;
	logic [11:0] m;
	int          fail_count  = 0;
	int          check_count = 0;
	int          n;
	int          at;

	always #4 sys_clk = ~sys_clk;

	light_sensor_ctrl #(.SHORT_CYCLES(SHORT), .LONG_CYCLES(LONG)) DUT (
		.sys_clk(sys_clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .adc_mantissa(adc_mantissa), .adc_overload(adc_overload),
		.high_limit(high_limit), .low_limit(low_limit), .result_data(result_data),
		.conv_active(conv_active), .res_drop_bits(res_drop_bits), .limit_alert(limit_alert));

	adc_front_model FE (.conv_active(conv_active), .light_level(light_level), .burst(burst),
		.adc_mantissa(adc_mantissa), .adc_overload(adc_overload));

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr

	function automatic logic [1:0] exp_drop(input logic [3:0] r, input logic long_sel);
		if (long_sel || r > 4'h5) return 2'h0;
		if (r == 4'h5) return 2'h1;
		if (r == 4'h0) return 2'h3;
		return 2'h2;
	endfunction : exp_drop

	task wr(input logic [15:0] v);
		@(negedge sys_clk);
		reg_wdata = v;
		reg_wr = 1'b1;
		@(negedge sys_clk);
		reg_wr = 1'b0;
	endtask : wr

	task rd();
		@(negedge sys_clk);
		reg_rd = 1'b1;
		@(negedge sys_clk);
		reg_rd = 1'b0;
	endtask : rd

	// Counts converting cycles; an overload burst is raised in cycle at (0 for none).
	task run(input int at_c, output int cnt);
		cnt = 0;
		while (conv_active === 1'b1 && cnt < 1000) begin
			cnt++;
			burst = (cnt == at_c);
			@(negedge sys_clk);
		end
		burst = 1'b0;
		if (cnt >= 1000) begin
			fail_count++;
		end
		repeat (2) @(negedge sys_clk);
	endtask : run

	task wait_done(output int cnt);
		cnt = 0;
		while (reg_rdata[7] !== 1'b1 && cnt < 1000) begin
			cnt++;
			@(negedge sys_clk);
		end
		if (cnt >= 1000) begin
			fail_count++;
		end
	endtask : wait_done

	task test_done();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : test_done

	initial begin
		#100000;
		fail_count++;
		test_done();
	end

	initial begin
		repeat (10) @(negedge sys_clk);
		rst_n = 1'b1;
		`CHK("conv_time_reset", 1'b1, reg_rdata[11])
		`CHK("mode_reset", 2'b00, reg_rdata[10:9])
		`CHK("fault_sel_reset", 2'b00, reg_rdata[1:0])
		`CHK("cfg_reset", `CFG_RESET, reg_rdata)
		$display("test reset done");
		for (int r = 0; r < 12; r++) begin
			for (int c = 0; c < 2; c++) begin
				wr({r[3:0], c[0], 2'b00, 9'h010});
				`CHK("drop_bits", exp_drop(r[3:0], c[0]), res_drop_bits)
				`CHK("conv_time_rw", c[0], reg_rdata[11])
			end
		end
		$display("test resolution done");
		rnd = lfsr(rnd);
		m = rnd[11:0] | 12'h008;
		light_level = m;
		high_limit = 16'h0000;
		wr(16'h0210);
		`CHK("mode_busy", 2'b01, reg_rdata[10:9])
		run(0, n);
		`CHK("short_len", SHORT, n)
		`CHK("mode_end", 2'b00, reg_rdata[10:9])
		`CHK("done_set", 1'b1, reg_rdata[7])
		`CHK("result", {4'h0, m & 12'hFF8}, result_data)
		`CHK("above", 1'b1, reg_rdata[6])
		wr(16'h0010);
		`CHK("done_kept", 1'b1, reg_rdata[7])
		`CHK("alert_kept", 1'b1, limit_alert)
		rd();
		`CHK("done_clr", 1'b0, reg_rdata[7])
		high_limit = 16'hBFFF;
		$display("test single done");
		wr(16'h5A10);
		run(0, n);
		`CHK("long_len", LONG, n)
		wr(16'h3210);
		`CHK("done_wr_clr", 1'b0, reg_rdata[7])
		run(3, n);
		`CHK("overload_set", 1'b1, reg_rdata[8])
		`CHK("manual_len", SHORT, n)
		wr(16'h3210);
		run(0, n);
		`CHK("overload_clr", 1'b0, reg_rdata[8])
		rnd = lfsr(rnd);
		at = 1 + int'(rnd[1:0]);
		wr(16'hC210);
		run(at, n);
		`CHK("auto_len", at + SHORT, n)
		`CHK("auto_range", 4'h1, result_data[15:12])
		$display("test overload done");
		for (int md = 2; md < 4; md++) begin
			wr({4'h0, 1'b0, md[1:0], 9'h010});
			repeat (4) @(negedge sys_clk);
			wr({4'h0, 1'b0, md[1:0], 9'h010});
			wait_done(n);
			`CHK("abort_len", SHORT, n)
			`CHK("cont_mode", md[1:0], reg_rdata[10:9])
			`CHK("cont_run", 1'b1, conv_active)
			wr(16'h0010);
			`CHK("stopped", 1'b0, conv_active)
			`CHK("done_stop", 1'b1, reg_rdata[7])
		end
		$display("test continuous done");
		for (int fsel = 0; fsel < 4; fsel++) begin
			low_limit = 16'h0000;
			wr(16'h0210 | 16'(fsel));
			run(0, n);
			rd();
			low_limit = 16'hBFFF;
			wr(16'h0410 | 16'(fsel));
			for (int k = 1; k <= (1 << fsel); k++) begin
				wait_done(n);
				@(negedge sys_clk);
				`CHK("below", 1'(k == (1 << fsel)), reg_rdata[5])
				if (k == (1 << fsel)) `CHK("alert_low", 1'b1, limit_alert)
				rd();
			end
			wr(16'h0010);
		end
		$display("test fault count done");
		test_done();
	end
endmodule : light_sensor_conversion_control_tb

`default_nettype wire

// *** light_sensor_ctrl.sv ***
/*
 * Conversion control and status register of an ambient light sensor:
 * modes, conversion timing, automatic range stepping, overload, ready and
 * limit flags.
 * Assumes the serial interface delivers decoded one-cycle read and write
 * strobes for this register, and the analog front end gives a mantissa and
 * an overload level synchronous to sys_clk.
 */
// What this block does
// - Conversion lasts either 100 ms or 800 ms, chosen by conversion time field.
// - Conversion time field is read/write and resets to one.
// - Short time drops one, two or three resolution bits at low ranges.
// - Result encoding and LSB weight never depend on conversion time.
// - Mode 00 shutdown, 01 single conversion, 10 or 11 continuous.
// - Mode field resets to shutdown.
// - Single mode reads 01 while converting, then self-clears to 00.
// - Entering shutdown keeps ready, limit flags and alert unchanged.
// - Overload flag is re-evaluated on every measurement, read-only.
// - Manual range overload may flag even with result below full scale.
// - In auto range only, overload below maximum range aborts conversion and steps range up.
// - Ready flag sets when a conversion finishes.
// - Ready clears on register read or non-shutdown write only.
// - Above flag sets after consecutive results over the high limit.
// - Below flag sets after consecutive results under the low limit.
// - Fault count codes select one, two, four or eight; default one.
// - Register write aborts conversion; restarts if written mode converts.
`timescale 1ns/1ps
`default_nettype none

module light_sensor_ctrl
	import light_sensor_pkg::*;
#(
	parameter int unsigned SHORT_CYCLES = `CONV_SHORT_MS * `CLK_CYCLES_PER_MS,
	parameter int unsigned LONG_CYCLES  = `CONV_LONG_MS * `CLK_CYCLES_PER_MS
) (
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [15:0] reg_wdata,
	output logic      [15:0] reg_rdata,
	input  wire logic [11:0] adc_mantissa,
	input  wire logic        adc_overload,
	input  wire logic [15:0] high_limit,
	input  wire logic [15:0] low_limit,
	output logic      [15:0] result_data,
	output logic             conv_active,
	output logic      [1:0]  res_drop_bits,
	output logic             limit_alert
);

	logic [3:0]  range_sel_ff;
	logic        conv_time_sel_ff;
	op_mode_t    mode_ff;
	logic        overload_flag_ff;
	logic        conv_done_flag_ff;
	logic        above_limit_flag_ff;
	logic        below_limit_flag_ff;
	logic        latch_ff;
	logic        pol_ff;
	logic        mask_exp_ff;
	logic [1:0]  consecutive_fault_sel_ff;
	conv_state_t state_ff;
	logic [26:0] cnt_ff;
	logic [3:0]  auto_range_ff;
	logic        ovl_seen_ff;
	logic [15:0] result_ff;

	op_mode_t    wr_mode;
	logic        auto_mode;
	logic [3:0]  active_range;
	logic [26:0] conv_last;
	logic        converting;
	logic        range_step;
	logic        conv_end;
	logic        single_end;
	logic        start_req;
	logic        restart;
	logic [11:0] kept_mant;
	logic [3:0]  result_exp;
	logic [22:0] meas_value;
	logic        hit_high;
	logic        hit_low;
	logic        fire_high;
	logic        fire_low;
	conv_state_t nxt_state;
	op_mode_t    nxt_mode;
	logic [26:0] nxt_cnt;
	logic        nxt_ovl_seen;
	logic        nxt_conv_done;
	logic        nxt_above;
	logic        nxt_below;

	assign wr_mode      = op_mode_t'(reg_wdata[`MODE_MSB:`MODE_LSB]);
	assign auto_mode    = (range_sel_ff >= `RANGE_AUTO);
	assign active_range = auto_mode ? auto_range_ff : range_sel_ff;
	assign conv_last    = conv_time_sel_ff ? 27'(LONG_CYCLES - 1) : 27'(SHORT_CYCLES - 1);
	assign converting   = (state_ff == ST_CONVERT);

	// A write takes precedence over everything the running conversion would do.
	assign range_step = converting && !reg_wr && adc_overload && auto_mode
		&& (auto_range_ff < `RANGE_MAX);
	assign conv_end   = converting && !reg_wr && !range_step && (cnt_ff == conv_last);
	assign single_end = conv_end && (mode_ff == MODE_SINGLE);
	assign start_req  = reg_wr && (wr_mode != MODE_SHUTDOWN);
	assign restart    = reg_wr || range_step || conv_end;

	// Short conversions zero the unresolved low bits; format and weight stay fixed.
	assign res_drop_bits = drop_bits(active_range, conv_time_sel_ff);
	assign kept_mant     = 12'(adc_mantissa & (12'hFFF << res_drop_bits));
	assign result_exp    = (mask_exp_ff && !auto_mode) ? 4'h0 : active_range;
	assign meas_value    = scale_value(active_range, kept_mant);
	assign hit_high      = meas_value > scale_value(high_limit[15:12], high_limit[11:0]);
	assign hit_low       = meas_value < scale_value(low_limit[15:12], low_limit[11:0]);

	assign nxt_state = reg_wr ? (start_req ? ST_CONVERT : ST_IDLE)
		: (single_end ? ST_IDLE : state_ff);
	assign nxt_mode  = reg_wr ? wr_mode : (single_end ? MODE_SHUTDOWN : mode_ff);
	assign nxt_cnt   = restart ? 27'h0000000 : (converting ? 27'(cnt_ff + 27'h0000001) : cnt_ff);
	assign nxt_ovl_seen = restart ? 1'b0 : (ovl_seen_ff || (converting && adc_overload));

	// Hardware set beats a clear in the same cycle; a shutdown write clears nothing.
	assign nxt_conv_done = conv_end || (conv_done_flag_ff && !reg_rd && !start_req);
	assign nxt_above     = fire_high || (above_limit_flag_ff && !reg_rd);
	assign nxt_below     = fire_low || (below_limit_flag_ff && !reg_rd);

	fault_qualifier u_high_qual (
		.sys_clk   (sys_clk),
		.rst_n     (rst_n),
		.step      (conv_end),
		.hit       (hit_high),
		.count_sel (consecutive_fault_sel_ff),
		.fire      (fire_high)
	);

	fault_qualifier u_low_qual (
		.sys_clk   (sys_clk),
		.rst_n     (rst_n),
		.step      (conv_end),
		.hit       (hit_low),
		.count_sel (consecutive_fault_sel_ff),
		.fire      (fire_low)
	);

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			range_sel_ff             <= `RANGE_RESET;
			conv_time_sel_ff         <= `CONV_TIME_RESET;
			latch_ff                 <= `LATCH_RESET;
			pol_ff                   <= `POL_RESET;
			mask_exp_ff              <= `ME_RESET;
			consecutive_fault_sel_ff <= `FAULT_SEL_RESET;
		end else if (reg_wr) begin
			range_sel_ff             <= reg_wdata[`RANGE_MSB:`RANGE_LSB];
			conv_time_sel_ff         <= reg_wdata[`CONV_TIME_BIT];
			latch_ff                 <= reg_wdata[`LATCH_BIT];
			pol_ff                   <= reg_wdata[`POL_BIT];
			mask_exp_ff              <= reg_wdata[`ME_BIT];
			consecutive_fault_sel_ff <= reg_wdata[`FAULT_SEL_MSB:`FAULT_SEL_LSB];
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_ff     <= MODE_SHUTDOWN;
			state_ff    <= ST_IDLE;
			cnt_ff      <= 27'h0000000;
			ovl_seen_ff <= 1'b0;
		end else begin
			mode_ff     <= nxt_mode;
			state_ff    <= nxt_state;
			cnt_ff      <= nxt_cnt;
			ovl_seen_ff <= nxt_ovl_seen;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			auto_range_ff <= `AUTO_RANGE_RESET;
		end else if (range_step) begin
			auto_range_ff <= 4'(auto_range_ff + 4'h1);
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			overload_flag_ff <= 1'b0;
			result_ff        <= 16'h0000;
		end else if (conv_end) begin
			overload_flag_ff <= ovl_seen_ff || adc_overload;
			result_ff        <= {result_exp, kept_mant};
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			conv_done_flag_ff   <= 1'b0;
			above_limit_flag_ff <= 1'b0;
			below_limit_flag_ff <= 1'b0;
		end else begin
			conv_done_flag_ff   <= nxt_conv_done;
			above_limit_flag_ff <= nxt_above;
			below_limit_flag_ff <= nxt_below;
		end
	end

	assign reg_rdata = {range_sel_ff, conv_time_sel_ff, mode_ff, overload_flag_ff, conv_done_flag_ff,
		above_limit_flag_ff, below_limit_flag_ff, latch_ff, pol_ff, mask_exp_ff, consecutive_fault_sel_ff};
	assign result_data = result_ff;
	assign conv_active = converting;
	assign limit_alert = above_limit_flag_ff || below_limit_flag_ff;

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);

	sequence seq_single_done;
		single_end && !reg_rd;
	endsequence

	sequence seq_shutdown_write;
		reg_wr && (wr_mode == MODE_SHUTDOWN) && !reg_rd && !conv_end;
	endsequence

	AST_CONV_LENGTH: assert property (converting |->
		(cnt_ff <= (conv_time_sel_ff ? 27'(LONG_CYCLES - 1) : 27'(SHORT_CYCLES - 1))))
		else $error("conversion ran past its selected length");
	AST_SHORT_DROP: assert property ((!conv_time_sel_ff && active_range == 4'h0) |-> res_drop_bits == 2'h3)
		else $error("range zero short conversion must drop three bits");
	AST_SHUTDOWN_IDLE: assert property ((mode_ff == MODE_SHUTDOWN) |-> !converting)
		else $error("converting while in shutdown");
	AST_SINGLE_SELF_CLEAR: assert property (seq_single_done |=>
		(mode_ff == MODE_SHUTDOWN) && !converting && conv_done_flag_ff)
		else $error("single conversion did not return to shutdown");
	AST_SHUTDOWN_KEEPS_FLAGS: assert property (seq_shutdown_write |=>
		$stable(conv_done_flag_ff) && (above_limit_flag_ff || !$past(above_limit_flag_ff)))
		else $error("shutdown write disturbed the status flags");
	AST_RANGE_STEP: assert property (range_step |=>
		(auto_range_ff == 4'($past(auto_range_ff) + 4'h1)) && (cnt_ff == 27'h0000000) && converting)
		else $error("overload did not restart at the next range");
	AST_READY_SET: assert property (conv_end |=> conv_done_flag_ff)
		else $error("ready flag missed a finished conversion");
	AST_READY_CLEAR: assert property ((reg_rd && !conv_end) |=> !conv_done_flag_ff)
		else $error("ready flag survived a register read");
	AST_WRITE_ABORT: assert property (reg_wr |=> (cnt_ff == 27'h0000000) && (converting == $past(start_req)))
		else $error("write did not abort or restart the conversion");
	AST_HIGH_FLAG: assert property ((conv_end && fire_high) |=> above_limit_flag_ff ##1
		(above_limit_flag_ff || $past(reg_rd)))
		else $error("above flag not held after qualification");

endmodule : light_sensor_ctrl

`default_nettype wire

// *** light_sensor_map.svh ***
/*
 * Constants of the conversion control and status register: field positions,
 * reset values and conversion timing.
 * Assumes inclusion by bare name from the package and the design modules.
 */
`ifndef LIGHT_SENSOR_MAP_SVH
`define LIGHT_SENSOR_MAP_SVH

`define CFG_RESET        16'hC810
`define RANGE_MSB        15
`define RANGE_LSB        12
`define CONV_TIME_BIT    11
`define MODE_MSB         10
`define MODE_LSB         9
`define OVERLOAD_BIT     8
`define CONV_DONE_BIT    7
`define ABOVE_BIT        6
`define BELOW_BIT        5
`define LATCH_BIT        4
`define POL_BIT          3
`define ME_BIT           2
`define FAULT_SEL_MSB    1
`define FAULT_SEL_LSB    0

`define RANGE_RESET      4'hC
`define RANGE_AUTO       4'hC
`define RANGE_MAX        4'hB
`define AUTO_RANGE_RESET 4'h0
`define CONV_TIME_RESET  1'b1
`define LATCH_RESET      1'b1
`define POL_RESET        1'b0
`define ME_RESET         1'b0
`define FAULT_SEL_RESET  2'h0

`define CONV_SHORT_MS    100
`define CONV_LONG_MS     800
`define CLK_CYCLES_PER_MS 125000

`endif

// *** light_sensor_pkg.sv ***
/*
 * Types shared by the conversion control block and its fault qualifier.
 * Assumes the constants header is on the include path.
 */
`include "light_sensor_map.svh"

package light_sensor_pkg;

	typedef enum logic [1:0] {
		MODE_SHUTDOWN = 2'b00,
		MODE_SINGLE   = 2'b01,
		MODE_CONT     = 2'b10,
		MODE_CONT_ALT = 2'b11
	} op_mode_t;

	typedef enum logic {
		ST_IDLE    = 1'b0,
		ST_CONVERT = 1'b1
	} conv_state_t;

	// Linear light value of an exponent and mantissa pair.
	function automatic logic [22:0] scale_value(input logic [3:0] expo, input logic [11:0] mant);
		scale_value = 23'({11'h000, mant} << expo);
	endfunction : scale_value

	// Low mantissa bits that carry no information at the short conversion time.
	function automatic logic [1:0] drop_bits(input logic [3:0] range, input logic long_time);
		if (long_time || range > 4'h5) begin
			drop_bits = 2'h0;
		end else if (range == 4'h5) begin
			drop_bits = 2'h1;
		end else if (range == 4'h0) begin
			drop_bits = 2'h3;
		end else begin
			drop_bits = 2'h2;
		end
	endfunction : drop_bits

endpackage : light_sensor_pkg
